// *** design/dmp_pkg.sv ***
package dmp_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 2;

  // Register index within a channel; address bit 3 selects the channel
  localparam logic [2:0] OFS_MODEM_CTRL = 3'h0;
  localparam logic [2:0] OFS_ENH_FEATURE = 3'h1;
  localparam logic [2:0] OFS_IRQ_ENABLE = 3'h2;
  localparam logic [2:0] OFS_DIVISOR_FRAC = 3'h3;
  localparam logic [2:0] OFS_IR_CTRL = 3'h4;
  localparam logic [2:0] OFS_MODEM_STATUS = 3'h5;
  localparam int CH_SEL_BIT = 3;

  // Field positions
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_OP2_BIT = 3;
  localparam int MCR_IR_BIT = 6;
  localparam int EFR_AUTO_RTS_BIT = 6;
  localparam int EFR_AUTO_CTS_BIT = 7;
  localparam int IER_AUTO_RTS_BIT = 6;
  localparam int IER_AUTO_CTS_BIT = 7;
  localparam int DLD_RS485_BIT = 6;
  localparam int IRC_INVERT_BIT = 0;
  localparam int MSR_CTS_BIT = 4;
  localparam int MSR_DSR_BIT = 5;
  localparam int MSR_RI_BIT = 6;
  localparam int MSR_CD_BIT = 7;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic RST_TX_PIN = 1'b1;
  localparam logic RST_OUT_N = 1'b1;

  // Decoder stretches one received pulse over one bit of 16 sample ticks
  localparam int IR_BIT_TICKS = 16;

  typedef struct packed {
    logic [7:0] modem_ctrl_reg;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] irq_enable_reg;
    logic [7:0] divisor_frac_reg;
    logic [7:0] ir_ctrl_reg;
  } dmp_ctrl_s;

  typedef struct packed {
    logic tx_bit;
    logic tx_busy;
    logic ir_window;
    logic sample_tick;
    logic rx_room;
    logic irq;
  } dmp_core_s;

  typedef struct packed {
    logic recv_in;
    logic clear_to_send_n;
    logic set_ready_n;
    logic carrier_detect_n;
    logic ring_indicator_n;
  } dmp_pin_in_s;

  typedef struct packed {
    logic xmit_out;
    logic req_to_send_n;
    logic terminal_ready_n;
    logic user_output_two_n;
    logic irq_out;
    logic irq_out_oe_n;
  } dmp_pin_out_s;
endpackage

// *** design/dmp_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmp_channel (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire dmp_pkg::dmp_ctrl_s i_ctrl,
  input wire dmp_pkg::dmp_core_s i_core,
  input wire dmp_pkg::dmp_pin_in_s i_pins,
  output var dmp_pkg::dmp_pin_out_s o_pins,
  output logic o_rx_data,
  output logic o_tx_allow,
  output logic [3:0] o_modem_status
);
  localparam logic [4:0] TICKS = 5'(dmp_pkg::IR_BIT_TICKS);
  logic ir_mode;
  logic auto_rts;
  logic auto_cts;
  logic rs485;
  logic ir_pulse;
  logic [4:0] ir_cnt;
  logic next_tx;
  logic next_rts_n;

  assign ir_mode = i_ctrl.modem_ctrl_reg[dmp_pkg::MCR_IR_BIT];
  assign auto_rts = i_ctrl.enhanced_feature_reg[dmp_pkg::EFR_AUTO_RTS_BIT]
                  & i_ctrl.irq_enable_reg[dmp_pkg::IER_AUTO_RTS_BIT];
  assign auto_cts = i_ctrl.enhanced_feature_reg[dmp_pkg::EFR_AUTO_CTS_BIT]
                  & i_ctrl.irq_enable_reg[dmp_pkg::IER_AUTO_CTS_BIT];
  assign rs485 = i_ctrl.divisor_frac_reg[dmp_pkg::DLD_RS485_BIT];

  // Inversion applied ahead of the decoder
  assign ir_pulse = i_pins.recv_in ^ i_ctrl.ir_ctrl_reg[dmp_pkg::IRC_INVERT_BIT];

  always_comb begin
    if (ir_mode) begin
      next_tx = ~i_core.tx_bit & i_core.ir_window;
    end else begin
      next_tx = i_core.tx_bit | ~i_core.tx_busy;
    end
  end

  always_comb begin
    if (rs485) begin
      next_rts_n = ~i_core.tx_busy;
    end else if (auto_rts) begin
      next_rts_n = ~(i_ctrl.modem_ctrl_reg[dmp_pkg::MCR_RTS_BIT] & i_core.rx_room);
    end else begin
      next_rts_n = ~i_ctrl.modem_ctrl_reg[dmp_pkg::MCR_RTS_BIT];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pins.xmit_out <= dmp_pkg::RST_TX_PIN;
    end else if (i_clk_en) begin
      o_pins.xmit_out <= next_tx;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pins.req_to_send_n <= dmp_pkg::RST_OUT_N;
      o_pins.terminal_ready_n <= dmp_pkg::RST_OUT_N;
    end else if (i_clk_en) begin
      o_pins.req_to_send_n <= next_rts_n;
      o_pins.terminal_ready_n <= ~i_ctrl.modem_ctrl_reg[dmp_pkg::MCR_DTR_BIT];
    end
  end

  // OP2 and interrupt enable move together from one bit
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pins.user_output_two_n <= dmp_pkg::RST_OUT_N;
      o_pins.irq_out_oe_n <= 1'b1;
      o_pins.irq_out <= 1'b0;
    end else if (i_clk_en) begin
      o_pins.user_output_two_n <= ~i_ctrl.modem_ctrl_reg[dmp_pkg::MCR_OP2_BIT];
      o_pins.irq_out_oe_n <= ~i_ctrl.modem_ctrl_reg[dmp_pkg::MCR_OP2_BIT];
      o_pins.irq_out <= i_core.irq;
    end
  end

  // A pulse holds the decoded line low for one bit time; a new pulse restarts it
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ir_cnt <= 5'h0;
    end else if (i_clk_en) begin
      if (ir_pulse) begin
        ir_cnt <= TICKS;
      end else if (i_core.sample_tick && ir_cnt != 5'h0) begin
        ir_cnt <= ir_cnt - 5'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rx_data <= 1'b1;
    end else if (i_clk_en) begin
      o_rx_data <= ir_mode ? (ir_cnt == 5'h0 && !ir_pulse) : i_pins.recv_in;
    end
  end

  // Without auto CTS the pin is only reported, never gating
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_allow <= 1'b1;
      o_modem_status <= 4'h0;
    end else if (i_clk_en) begin
      o_tx_allow <= ~auto_cts | ~i_pins.clear_to_send_n;
      o_modem_status <= {~i_pins.carrier_detect_n, ~i_pins.ring_indicator_n,
                         ~i_pins.set_ready_n, ~i_pins.clear_to_send_n};
    end
  end
endmodule
`default_nettype wire

// *** design/dmp_serial_pins.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Standard mode: transmit idles high, high in reset
// - Infrared mode: encoder path, transmit idles low
// - Infrared receive: optional inversion before decoder
// - RTS doubles as RS-485 direction control
// - CTS gates transmit under auto CTS
// - OP2 bit one: interrupt driven, OP2 low
// - OP2 bit zero: interrupt floats, OP2 high
// - DTR: active-low software-controlled output
// - CD, RI, DSR sampled active-low status inputs
module dmp_serial_pins (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic [dmp_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dmp_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [dmp_pkg::DATA_W-1:0] o_rdata,
  input wire dmp_pkg::dmp_core_s i_core_ch_a,
  input wire dmp_pkg::dmp_core_s i_core_ch_b,
  output logic o_rx_data_ch_a,
  output logic o_rx_data_ch_b,
  output logic o_tx_allow_ch_a,
  output logic o_tx_allow_ch_b,
  input wire logic i_recv_in_ch_a,
  input wire logic i_recv_in_ch_b,
  input wire logic i_clear_to_send_ch_a_n,
  input wire logic i_clear_to_send_ch_b_n,
  input wire logic i_set_ready_ch_a_n,
  input wire logic i_set_ready_ch_b_n,
  input wire logic i_carrier_detect_ch_a_n,
  input wire logic i_carrier_detect_ch_b_n,
  input wire logic i_ring_indicator_ch_a_n,
  input wire logic i_ring_indicator_ch_b_n,
  output logic o_xmit_out_ch_a,
  output logic o_xmit_out_ch_b,
  output logic o_req_to_send_ch_a_n,
  output logic o_req_to_send_ch_b_n,
  output logic o_terminal_ready_ch_a_n,
  output logic o_terminal_ready_ch_b_n,
  output logic o_user_output_two_ch_a_n,
  output logic o_user_output_two_ch_b_n,
  output logic o_irq_out_ch_a,
  output logic o_irq_out_ch_b,
  output logic o_irq_out_ch_a_oe_n,
  output logic o_irq_out_ch_b_oe_n
);
  dmp_pkg::dmp_core_s core [dmp_pkg::NUM_CH];
  dmp_pkg::dmp_pin_in_s pin_in [dmp_pkg::NUM_CH];
  dmp_pkg::dmp_pin_out_s pin_out [dmp_pkg::NUM_CH];
  dmp_pkg::dmp_ctrl_s ctrl [dmp_pkg::NUM_CH];
  logic [3:0] status [dmp_pkg::NUM_CH];
  logic rx_data [dmp_pkg::NUM_CH];
  logic tx_allow [dmp_pkg::NUM_CH];
  logic ch_sel;
  logic [2:0] reg_ofs;
  logic [dmp_pkg::DATA_W-1:0] next_rdata;

  assign ch_sel = i_addr[dmp_pkg::CH_SEL_BIT];
  assign reg_ofs = i_addr[2:0];

  assign core[0] = i_core_ch_a;
  assign core[1] = i_core_ch_b;
  assign pin_in[0] = '{recv_in: i_recv_in_ch_a, clear_to_send_n: i_clear_to_send_ch_a_n,
                       set_ready_n: i_set_ready_ch_a_n,
                       carrier_detect_n: i_carrier_detect_ch_a_n,
                       ring_indicator_n: i_ring_indicator_ch_a_n};
  assign pin_in[1] = '{recv_in: i_recv_in_ch_b, clear_to_send_n: i_clear_to_send_ch_b_n,
                       set_ready_n: i_set_ready_ch_b_n,
                       carrier_detect_n: i_carrier_detect_ch_b_n,
                       ring_indicator_n: i_ring_indicator_ch_b_n};

  // Each channel has its own register set and pin logic
  for (genvar ch = 0; ch < dmp_pkg::NUM_CH; ch++) begin : g_ch
    logic wr_here;
    assign wr_here = i_wr && (ch_sel == 1'(ch));

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        ctrl[ch] <= {5{dmp_pkg::RST_REG}};
      end else if (i_clk_en && wr_here) begin
        unique case (reg_ofs)
          dmp_pkg::OFS_MODEM_CTRL: ctrl[ch].modem_ctrl_reg <= i_wdata;
          dmp_pkg::OFS_ENH_FEATURE: ctrl[ch].enhanced_feature_reg <= i_wdata;
          dmp_pkg::OFS_IRQ_ENABLE: ctrl[ch].irq_enable_reg <= i_wdata;
          dmp_pkg::OFS_DIVISOR_FRAC: ctrl[ch].divisor_frac_reg <= i_wdata;
          dmp_pkg::OFS_IR_CTRL: ctrl[ch].ir_ctrl_reg <= i_wdata;
          default: begin
          end
        endcase
      end
    end

    dmp_channel u_chan (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_clk_en(i_clk_en),
      .i_ctrl(ctrl[ch]),
      .i_core(core[ch]),
      .i_pins(pin_in[ch]),
      .o_pins(pin_out[ch]),
      .o_rx_data(rx_data[ch]),
      .o_tx_allow(tx_allow[ch]),
      .o_modem_status(status[ch])
    );
  end

  always_comb begin
    next_rdata = '0;
    unique case (reg_ofs)
      dmp_pkg::OFS_MODEM_CTRL: next_rdata = ctrl[ch_sel].modem_ctrl_reg;
      dmp_pkg::OFS_ENH_FEATURE: next_rdata = ctrl[ch_sel].enhanced_feature_reg;
      dmp_pkg::OFS_IRQ_ENABLE: next_rdata = ctrl[ch_sel].irq_enable_reg;
      dmp_pkg::OFS_DIVISOR_FRAC: next_rdata = ctrl[ch_sel].divisor_frac_reg;
      dmp_pkg::OFS_IR_CTRL: next_rdata = ctrl[ch_sel].ir_ctrl_reg;
      dmp_pkg::OFS_MODEM_STATUS: next_rdata = {status[ch_sel], 4'h0};
      default: next_rdata = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else if (i_clk_en) begin
      o_rdata <= i_rd ? next_rdata : '0;
    end
  end

  assign o_rx_data_ch_a = rx_data[0];
  assign o_rx_data_ch_b = rx_data[1];
  assign o_tx_allow_ch_a = tx_allow[0];
  assign o_tx_allow_ch_b = tx_allow[1];
  assign o_xmit_out_ch_a = pin_out[0].xmit_out;
  assign o_xmit_out_ch_b = pin_out[1].xmit_out;
  assign o_req_to_send_ch_a_n = pin_out[0].req_to_send_n;
  assign o_req_to_send_ch_b_n = pin_out[1].req_to_send_n;
  assign o_terminal_ready_ch_a_n = pin_out[0].terminal_ready_n;
  assign o_terminal_ready_ch_b_n = pin_out[1].terminal_ready_n;
  assign o_user_output_two_ch_a_n = pin_out[0].user_output_two_n;
  assign o_user_output_two_ch_b_n = pin_out[1].user_output_two_n;
  assign o_irq_out_ch_a = pin_out[0].irq_out;
  assign o_irq_out_ch_b = pin_out[1].irq_out;
  assign o_irq_out_ch_a_oe_n = pin_out[0].irq_out_oe_n;
  assign o_irq_out_ch_b_oe_n = pin_out[1].irq_out_oe_n;
endmodule
`default_nettype wire

// *** verification/dmp_serial_pins_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmp_serial_pins_monitor (
  input wire logic i_sys_clk, i_rstn, i_clk_en, i_wr, i_rd,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata,
  input wire dmp_pkg::dmp_core_s i_core_ch_a,
  input wire logic i_recv_in_ch_a, i_clear_to_send_ch_a_n, i_carrier_detect_ch_a_n,
  input wire logic o_xmit_out_ch_a, o_req_to_send_ch_a_n, o_terminal_ready_ch_a_n,
  input wire logic o_user_output_two_ch_a_n, o_user_output_two_ch_b_n, o_irq_out_ch_a_oe_n,
  input wire logic o_tx_allow_ch_a, o_rx_data_ch_a
);
  logic [7:0] sh [16];
  logic ok;
  // Shadow of writes; ok is low on the first edge after reset so $past never sees reset data
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sh <= '{default: 8'h00};
      ok <= 1'b0;
    end else begin
      ok <= i_clk_en;
      if (i_wr && i_clk_en) begin
        sh[i_addr] <= i_wdata;
      end
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  a_dtr_from_reg:
    assert property (ok |-> o_terminal_ready_ch_a_n == !$past(sh[0][0])) else $error("dtr wrong");
  a_op2_ties_oe:
    assert property (o_user_output_two_ch_a_n == o_irq_out_ch_a_oe_n) else $error("op2 vs oe");
  a_op2_from_reg:
    assert property (ok |-> o_user_output_two_ch_a_n == !$past(sh[0][3])) else $error("op2 a");
  a_op2_chan_b:
    assert property (ok |-> o_user_output_two_ch_b_n == !$past(sh[8][3])) else $error("op2 b");
  a_tx_std_idle:
    assert property (ok && !$past(sh[0][6]) && !$past(i_core_ch_a.tx_busy) |-> o_xmit_out_ch_a)
      else $error("tx not idle high");
  a_tx_ir_idle:
    assert property (ok && $past(sh[0][6]) && $past(i_core_ch_a.tx_bit) |-> !o_xmit_out_ch_a)
      else $error("ir tx not idle low");
  a_cts_gates_tx:
    assert property (ok && $past(sh[1][7]) && $past(sh[2][7])
      |-> o_tx_allow_ch_a == !$past(i_clear_to_send_ch_a_n)) else $error("cts gate");
  a_rts_dir_ctrl:
    assert property (ok && $past(sh[3][6]) |-> o_req_to_send_ch_a_n == !$past(i_core_ch_a.tx_busy))
      else $error("rts direction");
  a_ir_rx_pulse:
    assert property (ok && $past(sh[0][6]) && ($past(i_recv_in_ch_a) != $past(sh[4][0]))
      |-> !o_rx_data_ch_a) else $error("ir pulse lost");
  a_status_read:
    assert property (ok && $past(ok) && $past(i_rd) && $past(i_addr) == 4'h5
      |-> o_rdata[7] == !$past(i_carrier_detect_ch_a_n, 2)) else $error("status cd");
  c_ir_mode: cover property (ok && $past(sh[0][6]) && !o_rx_data_ch_a);
  c_rs485: cover property (ok && $past(sh[3][6]) && !o_req_to_send_ch_a_n);
  c_cts_hold: cover property (ok && $past(sh[1][7]) && $past(sh[2][7]) && !o_tx_allow_ch_a);
endmodule
bind dmp_serial_pins dmp_serial_pins_monitor u_mon (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_wr(i_wr), .i_rd(i_rd),
  .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_core_ch_a(i_core_ch_a),
  .i_recv_in_ch_a(i_recv_in_ch_a), .i_clear_to_send_ch_a_n(i_clear_to_send_ch_a_n),
  .i_carrier_detect_ch_a_n(i_carrier_detect_ch_a_n), .o_xmit_out_ch_a(o_xmit_out_ch_a),
  .o_req_to_send_ch_a_n(o_req_to_send_ch_a_n),
  .o_terminal_ready_ch_a_n(o_terminal_ready_ch_a_n),
  .o_user_output_two_ch_a_n(o_user_output_two_ch_a_n),
  .o_user_output_two_ch_b_n(o_user_output_two_ch_b_n),
  .o_irq_out_ch_a_oe_n(o_irq_out_ch_a_oe_n), .o_tx_allow_ch_a(o_tx_allow_ch_a),
  .o_rx_data_ch_a(o_rx_data_ch_a)
);
`default_nettype wire

// *** verification/dmp_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmp_far_end (
  input wire logic i_ir,
  input wire logic i_inv,
  input wire logic i_send,
  input wire logic [3:0] i_modem,
  output logic o_recv_in,
  output logic [3:0] o_modem_n
);
  // Plain line rests high; an infrared transceiver rests at its own level
  assign o_recv_in = (i_ir ? i_inv : 1'b1) ^ i_send;
  assign o_modem_n = ~i_modem;
endmodule
`default_nettype wire

// *** verification/tb_dmp_serial_pins.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_dmp_serial_pins;
  logic i_sys_clk, i_rstn, i_clk_en, i_wr, i_rd, i_recv_in_ch_b, far_ir, far_inv, far_send;
  logic [3:0] i_addr, mda, mdb;
  logic [7:0] i_wdata, o_rdata;
  dmp_pkg::dmp_core_s i_core_ch_a, i_core_ch_b;
  logic o_rx_data_ch_a, o_rx_data_ch_b, o_tx_allow_ch_a, o_tx_allow_ch_b;
  logic o_xmit_out_ch_a, o_xmit_out_ch_b, o_req_to_send_ch_a_n, o_req_to_send_ch_b_n;
  logic o_terminal_ready_ch_a_n, o_terminal_ready_ch_b_n, o_irq_out_ch_a, o_irq_out_ch_b;
  logic o_user_output_two_ch_a_n, o_user_output_two_ch_b_n, o_irq_out_ch_a_oe_n, o_irq_out_ch_b_oe_n;
  wire i_recv_in_ch_a, i_clear_to_send_ch_a_n, i_set_ready_ch_a_n, i_carrier_detect_ch_a_n;
  wire i_ring_indicator_ch_a_n, i_clear_to_send_ch_b_n, i_set_ready_ch_b_n;
  wire i_carrier_detect_ch_b_n, i_ring_indicator_ch_b_n;
  int m [16];
  int num_errors, compares;
  assign {i_carrier_detect_ch_b_n, i_ring_indicator_ch_b_n, i_set_ready_ch_b_n,
    i_clear_to_send_ch_b_n} = ~mdb;
  dmp_serial_pins DUT (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_core_ch_a(i_core_ch_a), .i_core_ch_b(i_core_ch_b),
    .o_rx_data_ch_a(o_rx_data_ch_a), .o_rx_data_ch_b(o_rx_data_ch_b),
    .o_tx_allow_ch_a(o_tx_allow_ch_a), .o_tx_allow_ch_b(o_tx_allow_ch_b),
    .i_recv_in_ch_a(i_recv_in_ch_a), .i_recv_in_ch_b(i_recv_in_ch_b),
    .i_clear_to_send_ch_a_n(i_clear_to_send_ch_a_n),
    .i_clear_to_send_ch_b_n(i_clear_to_send_ch_b_n),
    .i_set_ready_ch_a_n(i_set_ready_ch_a_n), .i_set_ready_ch_b_n(i_set_ready_ch_b_n),
    .i_carrier_detect_ch_a_n(i_carrier_detect_ch_a_n),
    .i_carrier_detect_ch_b_n(i_carrier_detect_ch_b_n),
    .i_ring_indicator_ch_a_n(i_ring_indicator_ch_a_n),
    .i_ring_indicator_ch_b_n(i_ring_indicator_ch_b_n),
    .o_xmit_out_ch_a(o_xmit_out_ch_a), .o_xmit_out_ch_b(o_xmit_out_ch_b),
    .o_req_to_send_ch_a_n(o_req_to_send_ch_a_n), .o_req_to_send_ch_b_n(o_req_to_send_ch_b_n),
    .o_terminal_ready_ch_a_n(o_terminal_ready_ch_a_n),
    .o_terminal_ready_ch_b_n(o_terminal_ready_ch_b_n),
    .o_user_output_two_ch_a_n(o_user_output_two_ch_a_n),
    .o_user_output_two_ch_b_n(o_user_output_two_ch_b_n),
    .o_irq_out_ch_a(o_irq_out_ch_a), .o_irq_out_ch_b(o_irq_out_ch_b),
    .o_irq_out_ch_a_oe_n(o_irq_out_ch_a_oe_n), .o_irq_out_ch_b_oe_n(o_irq_out_ch_b_oe_n)
  );
  dmp_far_end u_far (.i_ir(far_ir), .i_inv(far_inv), .i_send(far_send), .i_modem(mda),
    .o_recv_in(i_recv_in_ch_a), .o_modem_n({i_carrier_detect_ch_a_n, i_ring_indicator_ch_a_n,
    i_set_ready_ch_a_n, i_clear_to_send_ch_a_n}));
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    if (a[2:0] < 3'h5) m[a] = d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task automatic idle(input int n);
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  function automatic logic [7:0] po(input int c);
    if (c == 0) return {1'b0, o_xmit_out_ch_a, o_req_to_send_ch_a_n, o_terminal_ready_ch_a_n,
      o_user_output_two_ch_a_n, o_irq_out_ch_a, o_irq_out_ch_a_oe_n, o_tx_allow_ch_a};
    return {1'b0, o_xmit_out_ch_b, o_req_to_send_ch_b_n, o_terminal_ready_ch_b_n,
      o_user_output_two_ch_b_n, o_irq_out_ch_b, o_irq_out_ch_b_oe_n, o_tx_allow_ch_b};
  endfunction
  function automatic logic [7:0] ex(input int c);
    logic [7:0] mc, ef, ie, dl;
    dmp_pkg::dmp_core_s k;
    mc = m[c*8][7:0];
    ef = m[c*8+1][7:0];
    ie = m[c*8+2][7:0];
    dl = m[c*8+3][7:0];
    k = c ? i_core_ch_b : i_core_ch_a;
    ex[7] = 1'b0;
    ex[6] = mc[6] ? (!k.tx_bit && k.ir_window) : (k.tx_bit || !k.tx_busy);
    ex[5] = dl[6] ? !k.tx_busy : (ef[6] && ie[6]) ? !(mc[1] && k.rx_room) : !mc[1];
    ex[4] = !mc[0];
    ex[3] = !mc[3];
    ex[2] = k.irq;
    ex[1] = !mc[3];
    ex[0] = !(ef[7] && ie[7]) || (c ? mdb[0] : mda[0]);
  endfunction
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    num_errors++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 8'h00, 8'h01);
    final_report();
  end
  initial begin
    {i_rstn, i_wr, i_rd, i_addr, i_wdata, far_ir, far_inv, far_send, mda, mdb} = '0;
    {i_clk_en, i_recv_in_ch_b} = 2'b11;
    {i_core_ch_a, i_core_ch_b} = '0;
    void'($urandom(32'h21a2_77ef));
    repeat (10) @(posedge i_sys_clk);
    #1 chk({o_xmit_out_ch_a, o_xmit_out_ch_b, o_user_output_two_ch_a_n,
      o_irq_out_ch_b_oe_n}, 8'h0f);
    repeat (10) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    $display("test reset done");
    for (int n = 0; n < 24; n++) begin
      int c;
      c = $urandom % 2;
      @(posedge i_sys_clk);
      i_core_ch_a <= 6'($urandom);
      i_core_ch_b <= 6'($urandom);
      mda <= 4'($urandom);
      mdb <= 4'($urandom);
      i_recv_in_ch_b <= 1'($urandom);
      // Auto RTS only enabled once the RTS bit is already set
      for (int r = 0; r < 6; r++) begin
        wr(4'(c*8+r), 8'($urandom) & (((r == 1 || r == 2) && !m[c*8][1]) ? 8'hbf : 8'hff));
      end
      far_ir <= m[0][6];
      idle(3);
      for (int cc = 0; cc < 2; cc++) begin
        chk(po(cc), ex(cc));
        if (!m[cc*8][6]) chk(8'(cc ? o_rx_data_ch_b : o_rx_data_ch_a),
          8'(cc ? i_recv_in_ch_b : i_recv_in_ch_a));
        rd(4'(cc*8+5), {cc ? mdb : mda, 4'h0});
      end
      for (int r = 0; r < 8; r++) if (r != 5) rd(4'(c*8+r), 8'(m[c*8+r]));
    end
    $display("test random done");
    for (int v = 0; v < 2; v++) begin
      wr(4'h0, 8'h40);
      wr(4'h4, 8'(v));
      far_ir <= 1'b1;
      far_inv <= 1'(v);
      i_core_ch_a <= 6'h04;
      idle(24);
      chk(8'(o_rx_data_ch_a), 8'h01);
      @(posedge i_sys_clk);
      far_send <= 1'b1;
      @(posedge i_sys_clk);
      far_send <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      #1 chk(8'(o_rx_data_ch_a), 8'h00);
      repeat (20) @(posedge i_sys_clk);
      #1 chk(8'(o_rx_data_ch_a), 8'h01);
    end
    $display("test infrared done");
    // A write offered to the modem control register while the enable is low must leave its DTR bit alone
    @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    i_wr <= 1'b1;
    i_addr <= 4'h0;
    i_wdata <= 8'h01;
    @(posedge i_sys_clk);
    i_clk_en <= 1'b1;
    i_wr <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1 chk(8'(o_terminal_ready_ch_a_n), 8'h01);
    $display("test enable done");
    final_report();
  end
endmodule
`default_nettype wire
